// File: design/bt_irq_pkg.sv
package bt_irq_pkg;

	////////////////////////////////////////////////////////////////////////
	// Serial link constants.
	localparam logic [6:0] SLAVE_ADDR = 7'h3c;
	localparam logic [3:0] BYTE_BITS = 4'h8;

	////////////////////////////////////////////////////////////////////////
	// Register offsets on the serial link.
	localparam logic [7:0] FLAGS_OFFSET = 8'h06;
	localparam logic [7:0] MASKS_OFFSET = 8'h0e;
	localparam logic [7:0] STATE_OFFSET = 8'h13;

	////////////////////////////////////////////////////////////////////////
	// Reset values; the live state register carries its fixed upper nibble.
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] MASKS_RESET = 8'h00;
	localparam logic [7:0] STATE_RESET = 8'h10;

	////////////////////////////////////////////////////////////////////////
	// Field positions shared by the mask, state and flag registers.
	localparam int unsigned LOW_BATT_BIT = 3;
	localparam int unsigned WARM_ALARM_BIT = 2;
	localparam int unsigned HOT_ALARM_BIT = 1;
	localparam int unsigned ALL_SOURCES_BIT = 0;
	localparam int unsigned DRIVE_BIT = 0;
	localparam int unsigned USED_BITS = 4;

	////////////////////////////////////////////////////////////////////////
	// The three comparator levels travel together.
	typedef struct packed {
		logic low_batt_level;
		logic warm_alarm_level;
		logic hot_alarm_level;
	} source_levels_type;

	// Serial link receiver states.
	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_ADDR = 9'h002,
		ST_ADDR_ACK = 9'h004,
		ST_PTR = 9'h008,
		ST_PTR_ACK = 9'h010,
		ST_WDATA = 9'h020,
		ST_WDATA_ACK = 9'h040,
		ST_RDATA = 9'h080,
		ST_RDATA_ACK = 9'h100
	} link_state_type;

endpackage

// File: design/bit_sync.sv
`timescale 1ns/1ns
// Two-flop synchroniser; only the second stage may be read.
module bit_sync
#(
	parameter int unsigned WIDTH = 1
)
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_ff;

	// The first stage feeds the second stage and nothing else.
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			meta_ff <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_ff <= async_in;
			sync_out <= meta_ff;
		end
	end

endmodule

// File: design/event_flag.sv
`timescale 1ns/1ns
// Sticky rising-edge flag with a clear that loses to a new edge.
module event_flag
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic level_in,
	input wire logic clear_in,
	output logic flag_out
);

	logic prev_ff;

	// Previous level, for edge detection.
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			prev_ff <= 1'b0;
		else
			prev_ff <= level_in;
	end

	// A set in the clearing cycle wins so no event is lost.
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			flag_out <= 1'b0;
		else
			flag_out <= (level_in & ~prev_ff) | (flag_out & ~clear_in);
	end

endmodule

// File: design/battery_thermal_irq_logic.sv
`timescale 1ns/1ns
module battery_thermal_irq_logic
(
	input wire logic CLK_IN,
	input wire logic SRST_IN,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE_N_OUT,
	input wire logic LOW_BATT_LEVEL_IN,
	input wire logic WARM_ALARM_LEVEL_IN,
	input wire logic HOT_ALARM_LEVEL_IN,
	input wire logic OTHER_IRQ_PENDING_IN,
	input wire logic MONITOR_GROUP_MASK_IN,
	output logic INTERRUPT_N_OUT,
	output logic INTERRUPT_OE_N_OUT,
	output logic TOP_PENDING_SUMMARY_OUT
);

	////////////////////////////////////////////////////////////////////////
	// Synchronised pins and comparator levels.
	logic [5:0] sync_bus;
	logic scl_s;
	logic sda_s;
	logic other_irq_s;
	bt_irq_pkg::source_levels_type levels_s;
	logic scl_q_ff;
	logic sda_q_ff;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;

	bit_sync #(
		.WIDTH(6)
	) u_sync (
		.clk_in(CLK_IN),
		.srst_in(SRST_IN),
		.async_in({SCL_IN, SDA_IN, OTHER_IRQ_PENDING_IN, LOW_BATT_LEVEL_IN,
			WARM_ALARM_LEVEL_IN, HOT_ALARM_LEVEL_IN}),
		.sync_out(sync_bus)
	);

	// Unpack the synchronised group; the analog levels travel as one struct.
	assign scl_s = sync_bus[5];
	assign sda_s = sync_bus[4];
	assign other_irq_s = sync_bus[3];
	assign levels_s = bt_irq_pkg::source_levels_type'(sync_bus[2:0]);

	// Delayed copies of the synchronised link lines for edge detection.
	always_ff @(posedge CLK_IN)
	begin
		if (SRST_IN)
		begin
			scl_q_ff <= 1'b1;
			sda_q_ff <= 1'b1;
		end
		else
		begin
			scl_q_ff <= scl_s;
			sda_q_ff <= sda_s;
		end
	end

	// Both lines pass the same synchroniser, so their skew is preserved.
	assign scl_rise = scl_s & ~scl_q_ff;
	assign scl_fall = ~scl_s & scl_q_ff;
	assign start_seen = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
	assign stop_seen = scl_s & scl_q_ff & ~sda_q_ff & sda_s;

	////////////////////////////////////////////////////////////////////////
	// Register state.
	logic [bt_irq_pkg::USED_BITS-1:0] masks_ff;
	logic [bt_irq_pkg::USED_BITS-1:0] flags;
	logic [bt_irq_pkg::USED_BITS-1:0] levels_vec;
	logic flag_clear;
	logic mask_write;
	logic [7:0] rx_ff;
	logic [7:0] ptr_ff;
	logic [7:0] rd_byte;

	assign levels_vec = {levels_s.low_batt_level, levels_s.warm_alarm_level,
		levels_s.hot_alarm_level, 1'b0};

	// One sticky flag per comparator; bit 0 is reserved and reads zero.
	assign flags[0] = 1'b0;
	genvar gi;
	generate
		for (gi = 1; gi < bt_irq_pkg::USED_BITS; gi++)
		begin : g_flag
			event_flag u_flag (
				.clk_in(CLK_IN),
				.srst_in(SRST_IN),
				.level_in(levels_vec[gi]),
				.clear_in(flag_clear),
				.flag_out(flags[gi])
			);
		end
	endgenerate

	// Mask register; reserved upper bits are not stored and read zero.
	always_ff @(posedge CLK_IN)
	begin
		if (SRST_IN)
			masks_ff <= bt_irq_pkg::MASKS_RESET[3:0];
		else if (mask_write)
			masks_ff <= rx_ff[3:0];
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt gating.
	logic [bt_irq_pkg::USED_BITS-1:0] unmasked_flags;
	logic group_pending;
	logic gate_drive;
	logic gate_drive_ff;

	// Reserved bit 0 of the flags is zero, so the global mask bit never
	// doubles as a per-source mask here.
	assign unmasked_flags = flags & ~masks_ff;
	assign group_pending = |unmasked_flags;
	assign gate_drive = (group_pending & ~MONITOR_GROUP_MASK_IN)
		| other_irq_s;

	// Pin, summary and software copy of the drive all come from flops.
	always_ff @(posedge CLK_IN)
	begin
		if (SRST_IN)
		begin
			gate_drive_ff <= 1'b0;
			INTERRUPT_OE_N_OUT <= 1'b1;
			TOP_PENDING_SUMMARY_OUT <= 1'b0;
		end
		else
		begin
			gate_drive_ff <= gate_drive;
			INTERRUPT_OE_N_OUT <= ~(gate_drive
				& ~masks_ff[bt_irq_pkg::ALL_SOURCES_BIT]);
			TOP_PENDING_SUMMARY_OUT <= group_pending;
		end
	end

	// Open-drain pin: only ever pulled low.
	assign INTERRUPT_N_OUT = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// Read data for the current pointer; unmapped offsets read zero.
	always_comb
	begin
		case (ptr_ff)
			bt_irq_pkg::FLAGS_OFFSET:
				rd_byte = bt_irq_pkg::FLAGS_RESET | {4'h0, flags};
			bt_irq_pkg::MASKS_OFFSET:
				rd_byte = {4'h0, masks_ff};
			bt_irq_pkg::STATE_OFFSET:
				rd_byte = bt_irq_pkg::STATE_RESET
					| {4'h0, levels_vec[3:1], gate_drive_ff};
			default:
				rd_byte = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Serial link slave.
	bt_irq_pkg::link_state_type state_ff;
	logic [3:0] bit_cnt_ff;
	logic [7:0] tx_ff;
	logic master_ack_ff;
	logic load_tx;
	logic data_slot;

	// A byte is loaded for sending after the address ack of a read, or
	// after the master acks the previous byte.
	assign load_tx = scl_fall
		& (((state_ff == bt_irq_pkg::ST_ADDR_ACK) & rx_ff[0])
		| ((state_ff == bt_irq_pkg::ST_RDATA_ACK) & ~master_ack_ff));

	// Ack slots neither count nor shift. The read/write bit then survives
	// into the address ack, and every byte counts its bits from zero.
	assign data_slot = (state_ff == bt_irq_pkg::ST_ADDR)
		| (state_ff == bt_irq_pkg::ST_PTR)
		| (state_ff == bt_irq_pkg::ST_WDATA)
		| (state_ff == bt_irq_pkg::ST_RDATA);

	// Reading the flag offset hands back the snapshot, then clears.
	assign flag_clear = load_tx & (ptr_ff == bt_irq_pkg::FLAGS_OFFSET);

	// Only the mask register takes writes; the live state register and
	// the flags ignore them, so any upper-nibble value is accepted.
	assign mask_write = scl_fall & (state_ff == bt_irq_pkg::ST_WDATA)
		& (bit_cnt_ff == bt_irq_pkg::BYTE_BITS)
		& (ptr_ff == bt_irq_pkg::MASKS_OFFSET);

	// Shift in one bit on each rising clock edge of a data slot.
	always_ff @(posedge CLK_IN)
	begin
		if (SRST_IN)
			rx_ff <= 8'h00;
		else if (scl_rise && data_slot)
			rx_ff <= {rx_ff[6:0], sda_s};
	end

	// Master acknowledge sampled during the read ack slot.
	always_ff @(posedge CLK_IN)
	begin
		if (SRST_IN)
			master_ack_ff <= 1'b1;
		else if (scl_rise && state_ff == bt_irq_pkg::ST_RDATA_ACK)
			master_ack_ff <= sda_s;
	end

	// Bit counter: counts rising edges within a byte.
	always_ff @(posedge CLK_IN)
	begin
		if (SRST_IN || start_seen)
			bit_cnt_ff <= 4'h0;
		else if (scl_fall && bit_cnt_ff == bt_irq_pkg::BYTE_BITS)
			bit_cnt_ff <= 4'h0;
		else if (scl_rise && data_slot)
			bit_cnt_ff <= bit_cnt_ff + 4'h1;
	end

	// Register pointer: set by the first written byte, then auto-increments.
	always_ff @(posedge CLK_IN)
	begin
		if (SRST_IN)
			ptr_ff <= 8'h00;
		else if (scl_fall && state_ff == bt_irq_pkg::ST_PTR
			&& bit_cnt_ff == bt_irq_pkg::BYTE_BITS)
			ptr_ff <= rx_ff;
		else if (load_tx || mask_write)
			ptr_ff <= ptr_ff + 8'h01;
		else if (scl_fall && state_ff == bt_irq_pkg::ST_WDATA
			&& bit_cnt_ff == bt_irq_pkg::BYTE_BITS)
			ptr_ff <= ptr_ff + 8'h01;
	end

	// Transmit shift register; the next bit goes out on each falling edge.
	always_ff @(posedge CLK_IN)
	begin
		if (SRST_IN)
			tx_ff <= 8'h00;
		else if (load_tx)
			tx_ff <= rd_byte;
		else if (scl_fall && state_ff == bt_irq_pkg::ST_RDATA)
			tx_ff <= {tx_ff[6:0], 1'b0};
	end

	// Link state machine; byte and ack moves happen as the clock line falls, start and stop moves while it is high.
	always_ff @(posedge CLK_IN)
	begin
		if (SRST_IN || stop_seen)
			state_ff <= bt_irq_pkg::ST_IDLE;
		else if (start_seen)
			state_ff <= bt_irq_pkg::ST_ADDR;
		else if (scl_fall)
		begin
			case (state_ff)
				bt_irq_pkg::ST_ADDR:
					if (bit_cnt_ff == bt_irq_pkg::BYTE_BITS)
						state_ff <= (rx_ff[7:1] == bt_irq_pkg::SLAVE_ADDR)
							? bt_irq_pkg::ST_ADDR_ACK : bt_irq_pkg::ST_IDLE;
				bt_irq_pkg::ST_ADDR_ACK:
					state_ff <= rx_ff[0] ? bt_irq_pkg::ST_RDATA
						: bt_irq_pkg::ST_PTR;
				bt_irq_pkg::ST_PTR:
					if (bit_cnt_ff == bt_irq_pkg::BYTE_BITS)
						state_ff <= bt_irq_pkg::ST_PTR_ACK;
				bt_irq_pkg::ST_PTR_ACK:
					state_ff <= bt_irq_pkg::ST_WDATA;
				bt_irq_pkg::ST_WDATA:
					if (bit_cnt_ff == bt_irq_pkg::BYTE_BITS)
						state_ff <= bt_irq_pkg::ST_WDATA_ACK;
				bt_irq_pkg::ST_WDATA_ACK:
					state_ff <= bt_irq_pkg::ST_WDATA;
				bt_irq_pkg::ST_RDATA:
					if (bit_cnt_ff == bt_irq_pkg::BYTE_BITS)
						state_ff <= bt_irq_pkg::ST_RDATA_ACK;
				bt_irq_pkg::ST_RDATA_ACK:
					state_ff <= master_ack_ff ? bt_irq_pkg::ST_IDLE
						: bt_irq_pkg::ST_RDATA;
				default:
					state_ff <= bt_irq_pkg::ST_IDLE;
			endcase
		end
	end

	// Data line drive: matched address, pointer and write-data ack slots pull low; the read ack slot is released; read bits pull low for zeros.
	// Changes only on a falling clock edge or a seen start or stop, so no false start or stop.
	always_ff @(posedge CLK_IN)
	begin
		if (SRST_IN || start_seen || stop_seen)
			SDA_OE_N_OUT <= 1'b1;
		else if (load_tx)
			SDA_OE_N_OUT <= rd_byte[7];
		else if (scl_fall)
		begin
			case (state_ff)
				bt_irq_pkg::ST_ADDR:
					SDA_OE_N_OUT <= ~((bit_cnt_ff == bt_irq_pkg::BYTE_BITS)
						&& (rx_ff[7:1] == bt_irq_pkg::SLAVE_ADDR));
				bt_irq_pkg::ST_PTR,
				bt_irq_pkg::ST_WDATA:
					SDA_OE_N_OUT <= bit_cnt_ff != bt_irq_pkg::BYTE_BITS;
				bt_irq_pkg::ST_RDATA:
					SDA_OE_N_OUT <= (bit_cnt_ff == bt_irq_pkg::BYTE_BITS)
						| tx_ff[6];
				default:
					SDA_OE_N_OUT <= 1'b1;
			endcase
		end
	end

	// Open-drain data pin: the driven level is always low.
	assign SDA_OUT = 1'b0;

endmodule

// File: verif/bt_irq_asserts.sv
`timescale 1ns/1ns
// Port-level checks on the battery and thermal interrupt block.
module bt_irq_asserts
(
	input wire logic CLK_IN,
	input wire logic SRST_IN,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	input wire logic SDA_OUT,
	input wire logic SDA_OE_N_OUT,
	input wire logic OTHER_IRQ_PENDING_IN,
	input wire logic MONITOR_GROUP_MASK_IN,
	input wire logic INTERRUPT_N_OUT,
	input wire logic INTERRUPT_OE_N_OUT,
	input wire logic TOP_PENDING_SUMMARY_OUT
);
	// Everything lives in the one system clock domain.
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (SRST_IN);

	////////////////////////////////////////////////////////////////////////
	// Shutdown leaves both pins released and nothing pending.
	chk_reset_pins_idle: assert property (
		$fell(SRST_IN) |-> SDA_OE_N_OUT && INTERRUPT_OE_N_OUT)
		else $error("pins not released after reset");
	chk_reset_summary_clear: assert property (
		$fell(SRST_IN) |-> !TOP_PENDING_SUMMARY_OUT)
		else $error("summary set after reset");
	// Open-drain pins may only ever pull low.
	chk_pin_drive_zero: assert property (INTERRUPT_N_OUT == 1'b0)
		else $error("interrupt drive value not zero");
	chk_sda_drive_zero: assert property (SDA_OUT == 1'b0)
		else $error("data drive value not zero");

	////////////////////////////////////////////////////////////////////////
	// The group mask leaves the pin to the other sources alone.
	chk_group_blocks: assert property (
		(MONITOR_GROUP_MASK_IN && !OTHER_IRQ_PENDING_IN) [*4]
		|=> INTERRUPT_OE_N_OUT)
		else $error("group mask did not block monitor flags");
	// A low pin needs a pending monitor flag or another source.
	chk_pin_has_cause: assert property (
		!INTERRUPT_OE_N_OUT |-> TOP_PENDING_SUMMARY_OUT
		|| $past(OTHER_IRQ_PENDING_IN, 2) || $past(OTHER_IRQ_PENDING_IN, 3)
		|| $past(OTHER_IRQ_PENDING_IN, 4))
		else $error("pin asserted without a cause");
	// Flags only clear through a read, so a quiet link keeps them.
	chk_flags_hold: assert property (
		$stable(SCL_IN) [*6] |-> !$fell(TOP_PENDING_SUMMARY_OUT))
		else $error("summary dropped without link activity");
	chk_sda_stands: assert property (
		($stable(SCL_IN) && $stable(SDA_IN)) [*5] |-> $stable(SDA_OE_N_OUT))
		else $error("data drive changed on an idle link");

	cover property ($fell(INTERRUPT_OE_N_OUT));
	cover property ($rose(TOP_PENDING_SUMMARY_OUT));
	cover property ($fell(SDA_OE_N_OUT));
endmodule

// File: verif/i2c_host_model.sv
`timescale 1ns/1ns
// Behavioural host on the serial link; the bench resolves the wire.
module i2c_host_model
(
	output logic scl_out,
	output logic sda_low_out,
	input wire logic sda_in
);
	// Idle bus: clock high, data released to the pull-up.
	initial
	begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// One 800 ns bit; data moves only while the clock is low.
	task automatic bit_io(input logic b, output logic r);
		sda_low_out = ~b;
		#200 scl_out = 1'b1;
		#200 r = sda_in;
		#200 scl_out = 1'b0;
		#200;
	endtask

	// Also serves as repeated start, entered with the clock low.
	task automatic start;
		sda_low_out = 1'b0;
		#200 scl_out = 1'b1;
		#200 sda_low_out = 1'b1;
		#200 scl_out = 1'b0;
		#200;
	endtask

	task automatic stop;
		sda_low_out = 1'b1;
		#200 scl_out = 1'b1;
		#200 sda_low_out = 1'b0;
		#400;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Sends a byte most significant bit first and folds in the acknowledge.
	task automatic put_byte(input logic [7:0] d, inout logic ok);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ok = ok & ~r;
	endtask

	task automatic write_reg(input logic [7:0] p, d, output logic ok);
		ok = 1'b1;
		start;
		put_byte({bt_irq_pkg::SLAVE_ADDR, 1'b0}, ok);
		put_byte(p, ok);
		put_byte(d, ok);
		stop;
	endtask

	// A refused byte turns the result unknown so no comparison passes.
	task automatic read_reg(input logic [7:0] p, output logic [7:0] d);
		logic ok;
		logic r;
		ok = 1'b1;
		start;
		put_byte({bt_irq_pkg::SLAVE_ADDR, 1'b0}, ok);
		put_byte(p, ok);
		start;
		put_byte({bt_irq_pkg::SLAVE_ADDR, 1'b1}, ok);
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(1'b1, r);
		stop;
		if (!ok)
			d = 8'hxx;
	endtask
endmodule

// File: verif/battery_thermal_irq_logic_tb.sv
`timescale 1ns/1ns
`define CHECK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
	num_errors++; $display("MISMATCH %s expected %h seen %h", n, e, g); \
	end end
module battery_thermal_irq_logic_tb;
	localparam logic [7:0] f_off = bt_irq_pkg::FLAGS_OFFSET;
	localparam logic [7:0] m_off = bt_irq_pkg::MASKS_OFFSET;
	localparam logic [7:0] s_off = bt_irq_pkg::STATE_OFFSET;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic scl;
	logic host_low;
	logic sda;
	bt_irq_pkg::source_levels_type lvl = '0;
	logic other = 1'b0;
	logic group = 1'b0;
	logic sda_oe_n;
	logic irq_oe_n;
	logic summary;
	int num_errors = 0;
	int check_count = 0;

	// Open-drain data line with a pull-up.
	assign sda = ~host_low & sda_oe_n;

	battery_thermal_irq_logic uut
	(
		.CLK_IN(clk),
		.SRST_IN(srst),
		.SCL_IN(scl),
		.SDA_IN(sda),
		.SDA_OUT(),
		.SDA_OE_N_OUT(sda_oe_n),
		.LOW_BATT_LEVEL_IN(lvl.low_batt_level),
		.WARM_ALARM_LEVEL_IN(lvl.warm_alarm_level),
		.HOT_ALARM_LEVEL_IN(lvl.hot_alarm_level),
		.OTHER_IRQ_PENDING_IN(other),
		.MONITOR_GROUP_MASK_IN(group),
		.INTERRUPT_N_OUT(),
		.INTERRUPT_OE_N_OUT(irq_oe_n),
		.TOP_PENDING_SUMMARY_OUT(summary)
	);
	i2c_host_model host
	(
		.scl_out(scl),
		.sda_low_out(host_low),
		.sda_in(sda)
	);

	////////////////////////////////////////////////////////////////////////
	// Ten megahertz system clock.
	initial
	begin
		forever #50 clk = ~clk;
	end

	task automatic print_verdict;
		if (num_errors == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Waits whole cycles and lands just after the edge, like all stimulus.
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] p, d);
		logic ok;
		host.write_reg(p, d, ok);
		`CHECK("write ack", 1'b1, ok)
	endtask

	task automatic rd(input logic [7:0] p, e, input string n);
		logic [7:0] v;
		host.read_reg(p, v);
		`CHECK(n, e, v)
	endtask

	task automatic pins(input logic p, s);
		`CHECK("irq pin", p, irq_oe_n)
		`CHECK("summary", s, summary)
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial
	begin
		wait_clk(6);
		srst = 1'b0;
		wait_clk(4);
		pins(1'b1, 1'b0);
		rd(m_off, bt_irq_pkg::MASKS_RESET, "masks reset");
		rd(s_off, bt_irq_pkg::STATE_RESET, "state reset");
		rd(f_off, bt_irq_pkg::FLAGS_RESET, "flags reset");
		wr(m_off, 8'hff);
		wr(8'h20, 8'h00);
		rd(m_off, 8'h0f, "masks reserved");
		wr(s_off, 8'hff);
		rd(s_off, 8'h10, "state read only");
		// Each source alone, unmasked; the falling edge must not set it.
		wr(m_off, 8'h00);
		for (int i = 0; i < 3; i++)
		begin
			lvl = 3'b100 >> i;
			wait_clk(6);
			pins(1'b0, 1'b1);
			rd(s_off, 8'h11 | {lvl, 1'b0}, "live state");
			rd(f_off, {4'h0, lvl, 1'b0}, "flags");
			rd(f_off, 8'h00, "flags cleared");
			pins(1'b1, 1'b0);
			lvl = '0;
			wait_clk(6);
		end
		// A hot edge that meets the clearing read keeps its flag. The
		// 29th clock fall of a read ends the read-address ack.
		fork
			rd(f_off, 8'h00, "flags edge on clear");
			begin
				repeat (29) @(negedge scl);
				lvl = 3'b001;
			end
		join
		rd(f_off, 8'h02, "flags kept");
		lvl = '0;
		wait_clk(6);
		// Source masks hide latched flags until unmasked.
		wr(m_off, 8'h0e);
		lvl = 3'b111;
		wait_clk(6);
		pins(1'b1, 1'b0);
		rd(s_off, 8'h1e, "masked state");
		wr(m_off, 8'h00);
		pins(1'b0, 1'b1);
		rd(f_off, 8'h0e, "masked flags");
		lvl = '0;
		wait_clk(6);
		// The all-sources mask against the group mask.
		wr(m_off, 8'h01);
		lvl = 3'b100;
		other = 1'b1;
		wait_clk(6);
		pins(1'b1, 1'b1);
		rd(s_off, 8'h19, "drive before mask");
		wr(m_off, 8'h00);
		group = 1'b1;
		wait_clk(6);
		pins(1'b0, 1'b1);
		other = 1'b0;
		wait_clk(6);
		pins(1'b1, 1'b1);
		group = 1'b0;
		wait_clk(2);
		pins(1'b0, 1'b1);
		// Shutdown in mid-run restores the masks.
		wr(m_off, 8'h0e);
		srst = 1'b1;
		wait_clk(2);
		srst = 1'b0;
		wait_clk(4);
		rd(m_off, 8'h00, "masks after shutdown");
		print_verdict();
	end

	// Cuts a hang short well beyond the expected run time.
	initial
	begin
		#2000000;
		num_errors++;
		print_verdict();
	end
endmodule

bind battery_thermal_irq_logic bt_irq_asserts chk
(
	.CLK_IN,
	.SRST_IN,
	.SCL_IN,
	.SDA_IN,
	.SDA_OUT,
	.SDA_OE_N_OUT,
	.OTHER_IRQ_PENDING_IN,
	.MONITOR_GROUP_MASK_IN,
	.INTERRUPT_N_OUT,
	.INTERRUPT_OE_N_OUT,
	.TOP_PENDING_SUMMARY_OUT
);
